// >>> design/ccs_regs.svh
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CCS_ADDR_W 3
`define CCS_OFS_STAT 3'h0
`define CCS_OFS_CTRL 3'h1
`define CCS_OFS_FLOAT 3'h2
`define CCS_OFS_CURR 3'h4
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CCS_CTRL_RST 8'h08
`define CCS_FLOAT_RST 6'h02
`define CCS_CURR_RST 8'h00
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CCS_KICK_BIT 7
`define CCS_CURR_MASK 8'h77
`define CCS_FAULT_TIMER 3'h6
`define CCS_FAULT_NONE 3'h0
// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define CCS_FLOAT_MAX_CODE 6'h2f
`define CCS_FLOAT_BASE_MV 13'h0dac
`define CCS_FLOAT_STEP_MV 13'h0014
`define CCS_FLOAT_MAX_MV 13'h1158
`define CCS_CHG_BASE_TUV 10'h176
`define CCS_CHG_STEP_TUV 10'h044
`define CCS_TERM_STEP_A 10'h022
`define CCS_TERM_STEP_B 10'h021
`define CCS_CHG_BASE_MA 11'h226
`define CCS_CHG_STEP_MA 11'h064
`define CCS_LIM_100_MA 11'h064
`define CCS_LIM_500_MA 11'h1f4
`define CCS_LIM_800_MA 11'h320
`define CCS_LIM_NONE_MA 11'h7ff
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CCS_CLK_HZ 64'd10000000
`define CCS_T_QUAL_MS 64'd32
`define CCS_T_CHECK_MS 64'd500
`define CCS_T_WDOG_S 64'd32
`define CCS_T_UNATT_MIN 64'd15
`define CCS_TMR_W 36
`endif

// >>> design/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_STAT_READY = 2'h0,
    CCS_STAT_CHARGING = 2'h1,
    CCS_STAT_DONE = 2'h2,
    CCS_STAT_FAULT = 2'h3
  } ccs_stat_t;
  typedef struct packed {
    logic batt_below_short;
    logic batt_below_recharge;
    logic batt_below_weak;
    logic por_ok;
    logic batt_present;
    logic current_below_term;
    logic reverse_over;
    logic otg_pin;
  } ccs_sense_t;
  typedef struct packed {
    logic [1:0] input_limit_code;
    logic [1:0] weak_batt_threshold;
    logic termination_enable;
    logic charge_inhibit;
    logic high_impedance_select;
    logic spare;
  } ccs_ctrl_t;
endpackage
`default_nettype wire

// >>> design/ccs_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic run,
  input wire logic [`CCS_TMR_W-1:0] limit,
  output logic expired
);
  logic [`CCS_TMR_W-1:0] cnt;
  logic [`CCS_TMR_W-1:0] next_cnt;
  logic next_expired;
  // ------------------------------------------------------------
  // Interval count
  // ------------------------------------------------------------
  always_comb
  begin
    next_cnt = cnt;
    next_expired = 1'b0;
    if (clear || !run)
      next_cnt = '0;
    else if (cnt == limit - `CCS_TMR_W'(1))
    begin
      next_cnt = '0;
      next_expired = 1'b1;
    end
    else
      next_cnt = cnt + `CCS_TMR_W'(1);
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= '0;
      expired <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

// >>> design/ccs_top.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_top #(
  parameter bit AUTO_CHARGE = 1'b1,
  parameter bit TERM_GROUP_B = 1'b0,
  parameter logic [`CCS_TMR_W-1:0] QUAL_CYC =
    `CCS_TMR_W'(`CCS_T_QUAL_MS * `CCS_CLK_HZ / 64'd1000),
  parameter logic [`CCS_TMR_W-1:0] CHECK_CYC =
    `CCS_TMR_W'(`CCS_T_CHECK_MS * `CCS_CLK_HZ / 64'd1000),
  parameter logic [`CCS_TMR_W-1:0] WDOG_CYC =
    `CCS_TMR_W'(`CCS_T_WDOG_S * `CCS_CLK_HZ),
  parameter logic [`CCS_TMR_W-1:0] UNATT_CYC =
    `CCS_TMR_W'(`CCS_T_UNATT_MIN * 64'd60 * `CCS_CLK_HZ)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`CCS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire ccs_pkg::ccs_sense_t sense,
  output logic precharge_en,
  output logic pwm_en,
  output logic rect_off,
  output logic [12:0] float_mv,
  output logic [9:0] chg_target_tuv,
  output logic [9:0] term_target_tuv,
  output logic [10:0] input_limit_ma,
  output logic [10:0] cc_limit_ma,
  output logic [1:0] charge_state
);
  import ccs_pkg::*;
  typedef enum logic [2:0] {
    CCS_OFF, CCS_PRE, CCS_FAST, CCS_CHECK, CCS_DONE
  } ccs_phase_t;
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  ccs_sense_t sense_m;
  ccs_sense_t sense_s;
  logic por_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sense_m <= '0;
      sense_s <= '0;
      por_q <= 1'b0;
    end
    else
    begin
      sense_m <= sense;
      sense_s <= sense_m;
      por_q <= sense_s.por_ok;
    end
  end
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ccs_phase_t phase, next_phase;
  ccs_ctrl_t ctrl, next_ctrl;
  logic [5:0] float_code, next_float_code;
  logic [7:0] curr, next_curr;
  logic [2:0] fault, next_fault;
  logic unatt_run, next_unatt_run;
  logic wdog_run, next_wdog_run;
  logic [7:0] next_rdata;
  logic qual_exp, check_exp, wdog_exp, unatt_exp;
  logic qual_run, wr_any, kick, unblock, may_charge, start;
  assign wr_any = wr;
  assign kick = wr && addr == `CCS_OFS_STAT && wdata[`CCS_KICK_BIT];
  assign qual_run = phase == CCS_FAST && ctrl.termination_enable &&
    sense_s.current_below_term;
  // ------------------------------------------------------------
  // Interval timers
  // ------------------------------------------------------------
  ccs_timer u_qual (
    .clk(clk), .reset_n(reset_n), .clear(1'b0), .run(qual_run),
    .limit(QUAL_CYC), .expired(qual_exp));
  ccs_timer u_check (
    .clk(clk), .reset_n(reset_n), .clear(1'b0),
    .run(phase == CCS_CHECK), .limit(CHECK_CYC),
    .expired(check_exp));
  ccs_timer u_wdog (
    .clk(clk), .reset_n(reset_n), .clear(wr_any || kick),
    .run(wdog_run), .limit(WDOG_CYC),
    .expired(wdog_exp));
  ccs_timer u_unatt (
    .clk(clk), .reset_n(reset_n), .clear(wr_any),
    .run(unatt_run), .limit(UNATT_CYC),
    .expired(unatt_exp));
  // ------------------------------------------------------------
  // Control and registers
  // ------------------------------------------------------------
  always_comb
  begin
    next_phase = phase;
    next_ctrl = ctrl;
    next_float_code = float_code;
    next_curr = curr;
    next_fault = fault;
    next_unatt_run = unatt_run;
    next_wdog_run = wdog_run;
    next_rdata = 8'h00;
    unblock = 1'b0;
    start = 1'b0;
    if (wr && addr == `CCS_OFS_CTRL)
    begin
      next_ctrl = ccs_ctrl_t'(wdata);
      unblock = (ctrl.charge_inhibit && !next_ctrl.charge_inhibit) ||
        (ctrl.high_impedance_select &&
        !next_ctrl.high_impedance_select);
    end
    else if (wr && addr == `CCS_OFS_FLOAT)
      next_float_code = wdata[7:2];
    else if (wr && addr == `CCS_OFS_CURR)
      next_curr = wdata & `CCS_CURR_MASK;
    if (rd && addr == `CCS_OFS_STAT)
    begin
      next_rdata = {2'h0, charge_state, 1'b0, fault};
      next_fault = `CCS_FAULT_NONE;
    end
    else if (rd && addr == `CCS_OFS_CTRL)
      next_rdata = ctrl;
    else if (rd && addr == `CCS_OFS_FLOAT)
      next_rdata = {float_code, 2'h0};
    else if (rd && addr == `CCS_OFS_CURR)
      next_rdata = curr;
    // Any host write hands the timing over to the watchdog.
    if (wr_any)
    begin
      next_unatt_run = 1'b0;
      next_wdog_run = 1'b1;
    end
    may_charge = !next_ctrl.charge_inhibit &&
      !next_ctrl.high_impedance_select &&
      sense_s.por_ok && sense_s.batt_present;
    case (phase)
      CCS_OFF:
      begin
        if (may_charge)
          start = 1'b1;
      end
      CCS_PRE:
      begin
        if (!sense_s.batt_below_short)
          next_phase = CCS_FAST;
      end
      CCS_FAST:
      begin
        if (qual_exp)
          next_phase = CCS_CHECK;
      end
      CCS_CHECK:
      begin
        if (check_exp)
          next_phase = (sense_s.batt_present && sense_s.por_ok) ?
            CCS_DONE : CCS_OFF;
      end
      CCS_DONE:
      begin
        if (sense_s.batt_below_recharge && may_charge)
          start = 1'b1;
      end
      default:
        next_phase = CCS_OFF;
    endcase
    if (AUTO_CHARGE && sense_s.por_ok && !por_q &&
        sense_s.batt_below_weak && may_charge)
      start = 1'b1;
    if (unblock && may_charge)
      start = 1'b1;
    if (phase != CCS_OFF && phase != CCS_DONE && !may_charge)
      next_phase = CCS_OFF;
    if (start)
    begin
      next_phase = sense_s.batt_below_short ? CCS_PRE : CCS_FAST;
      if (!next_wdog_run)
        next_unatt_run = 1'b1;
    end
    // Watchdog expiry overrides a host access in the same cycle; unattended expiry overrides only phase, charge_inhibit and fault.
    if (unatt_exp)
    begin
      next_phase = CCS_OFF;
      next_ctrl.charge_inhibit = 1'b1;
      next_fault = `CCS_FAULT_TIMER;
      next_unatt_run = 1'b0;
    end
    if (wdog_exp)
    begin
      next_phase = CCS_OFF;
      next_ctrl = ccs_ctrl_t'(`CCS_CTRL_RST);
      next_float_code = `CCS_FLOAT_RST;
      next_curr = `CCS_CURR_RST;
      next_fault = `CCS_FAULT_TIMER;
      next_wdog_run = 1'b0;
      next_unatt_run = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase <= CCS_OFF;
      ctrl <= ccs_ctrl_t'(`CCS_CTRL_RST);
      float_code <= `CCS_FLOAT_RST;
      curr <= `CCS_CURR_RST;
      fault <= `CCS_FAULT_NONE;
      unatt_run <= 1'b0;
      wdog_run <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      phase <= next_phase;
      ctrl <= next_ctrl;
      float_code <= next_float_code;
      curr <= next_curr;
      fault <= next_fault;
      unatt_run <= next_unatt_run;
      wdog_run <= next_wdog_run;
      rdata <= next_rdata;
    end
  end
  // ------------------------------------------------------------
  // Analog targets
  // ------------------------------------------------------------
  // Charge current is expressed for a 68 mOhm sense resistor; other
  // resistors scale the milliamp figures but not the sense targets.
  logic [12:0] next_float_mv;
  logic [9:0] next_chg_tuv, next_term_tuv;
  logic [10:0] next_lim_ma, next_cc_ma, chg_ma;
  logic [1:0] lim_code;
  logic [1:0] next_state;
  always_comb
  begin
    if (float_code >= `CCS_FLOAT_MAX_CODE)
      next_float_mv = `CCS_FLOAT_MAX_MV;
    else
      next_float_mv = `CCS_FLOAT_BASE_MV +
        13'(float_code) * `CCS_FLOAT_STEP_MV;
    next_chg_tuv = `CCS_CHG_BASE_TUV +
      10'(curr[6:4]) * `CCS_CHG_STEP_TUV;
    next_term_tuv = (10'(curr[2:0]) + 10'h001) *
      (TERM_GROUP_B ? `CCS_TERM_STEP_B : `CCS_TERM_STEP_A);
    chg_ma = `CCS_CHG_BASE_MA + 11'(curr[6:4]) * `CCS_CHG_STEP_MA;
    lim_code = ctrl.input_limit_code;
    if (AUTO_CHARGE && unatt_run)
      lim_code = {1'b0, sense_s.otg_pin};
    case (lim_code)
      2'h0: next_lim_ma = `CCS_LIM_100_MA;
      2'h1: next_lim_ma = `CCS_LIM_500_MA;
      2'h2: next_lim_ma = `CCS_LIM_800_MA;
      default: next_lim_ma = `CCS_LIM_NONE_MA;
    endcase
    next_cc_ma = (next_lim_ma < chg_ma) ? next_lim_ma : chg_ma;
    case (phase)
      CCS_PRE, CCS_FAST: next_state = CCS_STAT_CHARGING;
      CCS_DONE: next_state = CCS_STAT_DONE;
      CCS_CHECK: next_state = CCS_STAT_READY;
      default:
        next_state = (fault != `CCS_FAULT_NONE) ?
          CCS_STAT_FAULT : CCS_STAT_READY;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      precharge_en <= 1'b0;
      pwm_en <= 1'b0;
      rect_off <= 1'b0;
      float_mv <= '0;
      chg_target_tuv <= '0;
      term_target_tuv <= '0;
      input_limit_ma <= '0;
      cc_limit_ma <= '0;
      charge_state <= 2'h0;
    end
    else
    begin
      precharge_en <= phase == CCS_PRE;
      pwm_en <= phase == CCS_FAST;
      rect_off <= sense_s.reverse_over;
      float_mv <= next_float_mv;
      chg_target_tuv <= next_chg_tuv;
      term_target_tuv <= next_term_tuv;
      input_limit_ma <= next_lim_ma;
      cc_limit_ma <= next_cc_ma;
      charge_state <= next_state;
    end
  end
endmodule
`default_nettype wire

// >>> test/ccs_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_top_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire ccs_pkg::ccs_sense_t sense,
  input wire logic precharge_en,
  input wire logic pwm_en,
  input wire logic rect_off,
  input wire logic [12:0] float_mv,
  input wire logic [9:0] chg_target_tuv,
  input wire logic [9:0] term_target_tuv,
  input wire logic [10:0] input_limit_ma,
  input wire logic [10:0] cc_limit_ma,
  input wire logic [1:0] charge_state
);
  import ccs_pkg::*;
  // ----------------------------------------
  // Age since reset release
  // ----------------------------------------
  // Outputs stay zero in reset, so range checks wait one edge.
  logic [2:0] age;
  logic [2:0] next_age;
  always_comb next_age = (age == 3'h7) ? age : age + 3'h1;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) age <= 3'h0;
    else age <= next_age;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_enter_done;
    $past(charge_state) != CCS_STAT_DONE ##0 charge_state == CCS_STAT_DONE;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_float_grid: assert property (age != 3'h0 |->
    float_mv >= `CCS_FLOAT_BASE_MV && float_mv <= `CCS_FLOAT_MAX_MV &&
    (float_mv - `CCS_FLOAT_BASE_MV) % `CCS_FLOAT_STEP_MV == 13'h0000)
    else $error("float target off grid");
  a_chg_grid: assert property (age != 3'h0 |->
    chg_target_tuv >= `CCS_CHG_BASE_TUV && chg_target_tuv <= 10'h352 &&
    (chg_target_tuv - `CCS_CHG_BASE_TUV) % `CCS_CHG_STEP_TUV == 10'h000)
    else $error("charge target off grid");
  a_term_grid: assert property (age != 3'h0 |->
    term_target_tuv != 10'h000 && term_target_tuv <= 10'h110 &&
    term_target_tuv % `CCS_TERM_STEP_A == 10'h000)
    else $error("termination threshold off grid");
  a_limit_codes: assert property (age != 3'h0 |-> input_limit_ma inside
    {`CCS_LIM_100_MA, `CCS_LIM_500_MA, `CCS_LIM_800_MA, `CCS_LIM_NONE_MA})
    else $error("input limit not a legal value");
  a_cc_lower: assert property (cc_limit_ma <= input_limit_ma)
    else $error("current limit above input limit");
  a_phase_excl: assert property (!(precharge_en && pwm_en))
    else $error("pre-charge and switching both on");
  a_rect_follow: assert property (age == 3'h7 |->
    rect_off == $past(sense.reverse_over, 3))
    else $error("rectifier off does not follow reverse current");
  a_done_via_check: assert property (s_enter_done |->
    $past(charge_state) == CCS_STAT_READY)
    else $error("done entered without ready check");
endmodule
`default_nettype wire

// >>> test/ccs_host.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial
  begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // The watchdog survives if this or any other host write comes inside its period.
  task automatic kick();
    write(3'h0, 8'h80);
  endtask
endmodule
`default_nettype wire

// >>> test/charge_cycle_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_tb;
  import ccs_pkg::*;
  logic clk, reset_n, wr, rd, precharge_en, pwm_en, rect_off;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rv;
  ccs_sense_t sense;
  logic [12:0] float_mv;
  logic [9:0] chg_target_tuv, term_target_tuv;
  logic [10:0] input_limit_ma, cc_limit_ma;
  logic [1:0] charge_state;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  int unsigned seed = 69689;
  int fq[$] = '{0, 2, 46, 47, 63};
  int lims[4] = '{100, 500, 800, 2047};
  // Short counts keep the run brief; expectations follow these.
  ccs_top #(.QUAL_CYC(36'h14), .CHECK_CYC(36'h28), .WDOG_CYC(36'hc8),
    .UNATT_CYC(36'h190)) DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sense(sense),
    .precharge_en(precharge_en), .pwm_en(pwm_en), .rect_off(rect_off),
    .float_mv(float_mv), .chg_target_tuv(chg_target_tuv),
    .term_target_tuv(term_target_tuv), .input_limit_ma(input_limit_ma),
    .cc_limit_ma(cc_limit_ma), .charge_state(charge_state));
  ccs_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input int exp);
    samples_checked++;
    if (seen !== 16'(exp))
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input int exp);
    logic [7:0] v;
    host.read(a, v);
    chk(v, exp);
  endtask
  task automatic wait_state(input logic [1:0] st, output int k);
    k = 0;
    while (charge_state !== st && k < 500)
    begin
      tick(1);
      k++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    sense = 8'hb9;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    tick(8);
    chk({precharge_en, pwm_en}, 2);
    chk(input_limit_ma, 500);
    chk(float_mv, 3540);
    rdchk(3'h1, 8'h08);
    rdchk(3'h2, 8'h08);
    rdchk(3'h3, 8'h00);
    @(posedge clk) sense.batt_below_short <= 1'b0;
    tick(6);
    chk({precharge_en, pwm_en}, 1);
    $display("test phases done");
    for (n = 0; n < 3; n++) fq.push_back(xs() % 64);
    foreach (fq[i])
    begin
      host.write(3'h2, 8'(fq[i] << 2));
      tick(2);
      chk(float_mv, (fq[i] >= 47) ? 4440 : 3500 + 20 * fq[i]);
      rdchk(3'h2, fq[i] << 2);
    end
    for (n = 0; n < 8; n++)
    begin
      rv = {2'(n), 2'(xs()), 4'h8};
      host.write(3'h1, rv);
      rdchk(3'h1, rv);
      rv = {1'b0, 3'(n), 1'b0, 3'(xs())};
      host.write(3'h4, rv);
      tick(2);
      rdchk(3'h4, rv);
      chk(chg_target_tuv, 374 + 68 * n);
      chk(term_target_tuv, 34 * (rv[2:0] + 1));
      chk(input_limit_ma, lims[n % 4]);
      chk(cc_limit_ma, (lims[n % 4] < 550 + 100 * n) ? lims[n % 4] :
        550 + 100 * n);
    end
    $display("test fields done");
    repeat (4)
    begin
      tick(150);
      host.kick();
    end
    chk(charge_state, 1);
    tick(220);
    chk(float_mv, 3540);
    chk(input_limit_ma, 500);
    @(posedge clk) sense.otg_pin <= 1'b0;
    tick(4);
    chk(input_limit_ma, 100);
    @(posedge clk) sense.otg_pin <= 1'b1;
    rdchk(3'h1, 8'h08);
    rdchk(3'h0, 8'h16);
    wait_state(2'h3, n);
    chk({charge_state, pwm_en}, 6);
    rdchk(3'h1, 8'h0c);
    rdchk(3'h0, 8'h36);
    host.write(3'h1, 8'h08);
    tick(6);
    chk({charge_state, pwm_en}, 3);
    $display("test timers done");
    @(posedge clk) sense.current_below_term <= 1'b1;
    tick(12);
    @(posedge clk) sense.current_below_term <= 1'b0;
    tick(20);
    chk(pwm_en, 1);
    host.write(3'h1, 8'h00);
    @(posedge clk) sense.current_below_term <= 1'b1;
    tick(40);
    chk(pwm_en, 1);
    @(posedge clk) sense.current_below_term <= 1'b0;
    host.write(3'h1, 8'h08);
    @(posedge clk) sense.current_below_term <= 1'b1;
    n = 0;
    while (pwm_en !== 1'b0 && n < 60)
    begin
      tick(1);
      n++;
    end
    chk(n >= 20 && n <= 26, 1);
    chk(charge_state, 0);
    wait_state(2'h2, n);
    chk({charge_state, n >= 36}, 5);
    @(posedge clk) sense.batt_below_recharge <= 1'b1;
    tick(6);
    chk({charge_state, pwm_en}, 3);
    @(posedge clk) sense.reverse_over <= 1'b1;
    tick(4);
    chk(rect_off, 1);
    @(posedge clk) sense.reverse_over <= 1'b0;
    tick(4);
    chk(rect_off, 0);
    $display("test termination done");
    tally_and_finish();
  end
endmodule
bind ccs_top ccs_top_props u_props (.clk(clk), .reset_n(reset_n), .rd(rd),
  .rdata(rdata), .sense(sense), .precharge_en(precharge_en),
  .pwm_en(pwm_en), .rect_off(rect_off), .float_mv(float_mv),
  .chg_target_tuv(chg_target_tuv), .term_target_tuv(term_target_tuv),
  .input_limit_ma(input_limit_ma), .cc_limit_ma(cc_limit_ma),
  .charge_state(charge_state));
`default_nettype wire
